/* File: hw/lsd_pkg.sv */
// constants shared by the segment lcd drive control block.
// assumes a byte-wide register port and a 25 MHz system clock.
package lsd_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [1:0] ADDR_PIN_FUNC  = 2'h0;
   localparam logic [1:0] ADDR_MAIN_CTRL = 2'h1;
   localparam logic [1:0] ADDR_WAVE_CTRL = 2'h2;
   localparam logic [1:0] ADDR_CLK_RUN   = 2'h3;

   localparam logic [7:0] PIN_FUNC_RESET  = 8'h00;
   localparam logic [7:0] MAIN_CTRL_RESET = 8'h80;
   localparam logic [7:0] WAVE_CTRL_RESET = 8'h7F;
   localparam logic [7:0] CLK_RUN_RESET   = 8'hFF;

   localparam logic [7:0] MAIN_FIXED_ONES = 8'h80;
   localparam logic [7:0] WAVE_FIXED_ONES = 8'h60;
   localparam logic [7:0] CLK_FIXED_ONES  = 8'hFE;
   localparam logic [7:0] PIN_WR_MASK     = 8'hEF;
   localparam logic [7:0] MAIN_WR_MASK    = 8'h7F;
   localparam logic [7:0] WAVE_WR_MASK    = 8'h9F;
   localparam logic [7:0] CLK_WR_MASK     = 8'h01;

   // field positions
   localparam int PF_DUTY_HI    = 7;
   localparam int PF_DUTY_LO    = 6;
   localparam int PF_COM_REPEAT = 5;
   localparam int PF_GROUP_HI   = 3;
   localparam int MC_SUPPLY     = 6;
   localparam int MC_ACTIVATE   = 5;
   localparam int MC_SHOW       = 4;
   localparam int MC_SYS_SRC    = 3;
   localparam int MC_DIV_HI     = 2;
   localparam int WC_WAVE_B     = 7;
   localparam int CR_RUN        = 0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LSD_DUTY_STATIC  = 2'h0,
      LSD_DUTY_HALF    = 2'h1,
      LSD_DUTY_THIRD   = 2'h2,
      LSD_DUTY_QUARTER = 2'h3
   } lsd_duty_e;

   // frame is 256 source ticks, except one-third duty: three 64-tick slots, 192 ticks
   localparam logic [7:0] SLOT_STATIC = 8'hFF;
   localparam logic [7:0] SLOT_HALF   = 8'h7F;
   localparam logic [7:0] SLOT_SHORT  = 8'h3F;
   localparam int         GROUP_PINS  = 4;
   localparam logic [3:0] GROUP_ALL   = 4'h8;
endpackage : lsd_pkg

/* File: hw/lsd_segment_drive.sv */
// segment lcd drive control: registers, frame timing, pin functions.
// assumes a byte register port on clk and an asynchronous subclock pin.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
module lsd_segment_drive #(
   parameter int SEG_GROUPS = 8
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [1:0]                regAddr,
   input  wire logic [7:0]                regWdata,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   output      logic [7:0]                regRdata,
   input  wire logic                      subClkIn,
   input  wire logic                      lowPowerMode,
   input  wire logic                      standbyMode,
   input  wire logic [SEG_GROUPS*4-1:0]   memRowData,
   output      logic [1:0]                memRowSel,
   output      logic [3:0]                comDrive,
   output      logic                      alternation,
   output      logic                      waveformB,
   output      logic [SEG_GROUPS*4-1:0]   segData,
   output      logic [SEG_GROUPS*4-1:0]   segPinEnable,
   output      logic                      driveSupplyOn,
   output      logic                      frameTick
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] pinFunc_q;
   logic [7:0] mainCtrl_q;
   logic [7:0] waveCtrl_q;
   logic [7:0] clkRun_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pinFunc_q  <= lsd_pkg::PIN_FUNC_RESET;
         mainCtrl_q <= lsd_pkg::MAIN_CTRL_RESET;
         waveCtrl_q <= lsd_pkg::WAVE_CTRL_RESET;
         clkRun_q   <= lsd_pkg::CLK_RUN_RESET;
      end
      else if (regWrite)
      begin
         unique case (regAddr)
            lsd_pkg::ADDR_PIN_FUNC:
               pinFunc_q <= regWdata & lsd_pkg::PIN_WR_MASK;
            lsd_pkg::ADDR_MAIN_CTRL:
               mainCtrl_q <= (regWdata & lsd_pkg::MAIN_WR_MASK)
                             | lsd_pkg::MAIN_FIXED_ONES;
            // bit 4 is stored as written; software keeps it zero
            lsd_pkg::ADDR_WAVE_CTRL:
               waveCtrl_q <= (regWdata & lsd_pkg::WAVE_WR_MASK)
                             | lsd_pkg::WAVE_FIXED_ONES;
            lsd_pkg::ADDR_CLK_RUN:
               clkRun_q <= (regWdata & lsd_pkg::CLK_WR_MASK)
                           | lsd_pkg::CLK_FIXED_ONES;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         regRdata <= 8'h00;
      else if (regRead)
      begin
         unique case (regAddr)
            lsd_pkg::ADDR_PIN_FUNC:  regRdata <= pinFunc_q;
            lsd_pkg::ADDR_MAIN_CTRL: regRdata <= mainCtrl_q;
            lsd_pkg::ADDR_WAVE_CTRL: regRdata <= waveCtrl_q;
            lsd_pkg::ADDR_CLK_RUN:   regRdata <= clkRun_q;
         endcase
      end
      else
         regRdata <= 8'h00;
   end

   // ------------------------------------------------------------
   // decoded controls
   // ------------------------------------------------------------
   logic       running;
   logic       comRepeat;
   logic       sysSource;
   logic [1:0] duty;
   logic [2:0] divSel;

   assign duty      = pinFunc_q[lsd_pkg::PF_DUTY_HI:lsd_pkg::PF_DUTY_LO];
   assign comRepeat = pinFunc_q[lsd_pkg::PF_COM_REPEAT];
   assign sysSource = mainCtrl_q[lsd_pkg::MC_SYS_SRC];
   assign divSel    = mainCtrl_q[lsd_pkg::MC_DIV_HI:0];
   // halted or in module standby: timing counters held at zero, registers kept
   assign running   = mainCtrl_q[lsd_pkg::MC_ACTIVATE] & clkRun_q[lsd_pkg::CR_RUN];

   // ------------------------------------------------------------
   // subclock pin synchroniser and edge
   // ------------------------------------------------------------
   logic [2:0] subSync_q;
   logic       subLevel_q;
   logic       subRise;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         subSync_q  <= 3'h0;
         subLevel_q <= 1'b0;
      end
      else
      begin
         subSync_q <= {subSync_q[1:0], subClkIn};
         if (subSync_q[1] == subSync_q[2])
            subLevel_q <= subSync_q[2];
      end
   end

   assign subRise = (subSync_q[1] == subSync_q[2]) & subSync_q[2] & ~subLevel_q;

   // ------------------------------------------------------------
   // operating clock tick
   // ------------------------------------------------------------
   logic [7:0] sysDiv_q;
   logic [1:0] subDiv_q;
   logic       sysTick;
   logic       subTick;
   logic       srcTick;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sysDiv_q <= 8'h00;
         subDiv_q <= 2'h0;
      end
      else if (!running)
      begin
         sysDiv_q <= 8'h00;
         subDiv_q <= 2'h0;
      end
      else
      begin
         sysDiv_q <= sysDiv_q + 8'h01;
         if (subRise)
            subDiv_q <= subDiv_q + 2'h1;
      end
   end

   // system clock divided by 2 << divSel: tick when the low divSel+1 bits are all one; subclock by 1, 2 or 4
   always_comb
   begin
      sysTick = ((sysDiv_q | ~(8'hFF >> (3'h7 - divSel))) == 8'hFF);
      unique case (divSel[1:0])
         2'h0:    subTick = subRise;
         2'h1:    subTick = subRise & subDiv_q[0];
         default: subTick = subRise & (subDiv_q == 2'h3);
      endcase
   end

   // system clock is halted in low-power modes, so its sources stop
   assign srcTick = running & (sysSource ? (sysTick & ~lowPowerMode) : subTick);

   // ------------------------------------------------------------
   // common scan
   // ------------------------------------------------------------
   logic [7:0] slotCnt_q;
   logic [1:0] comIdx_q;
   logic [7:0] slotLast;
   logic [1:0] comLast;
   logic       slotEnd;
   logic       frameEnd;

   always_comb
   begin
      unique case (duty)
         lsd_pkg::LSD_DUTY_STATIC:
         begin
            slotLast = lsd_pkg::SLOT_STATIC;
            comLast  = 2'h0;
         end
         lsd_pkg::LSD_DUTY_HALF:
         begin
            slotLast = lsd_pkg::SLOT_HALF;
            comLast  = 2'h1;
         end
         lsd_pkg::LSD_DUTY_THIRD:
         begin
            slotLast = lsd_pkg::SLOT_SHORT;
            comLast  = 2'h2;
         end
         default:
         begin
            slotLast = lsd_pkg::SLOT_SHORT;
            comLast  = 2'h3;
         end
      endcase
   end

   assign slotEnd  = srcTick & (slotCnt_q >= slotLast);
   assign frameEnd = slotEnd & (comIdx_q >= comLast);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         slotCnt_q <= 8'h00;
         comIdx_q  <= 2'h0;
      end
      else if (!running)
      begin
         slotCnt_q <= 8'h00;
         comIdx_q  <= 2'h0;
      end
      else if (slotEnd)
      begin
         slotCnt_q <= 8'h00;
         comIdx_q  <= frameEnd ? 2'h0 : comIdx_q + 2'h1;
      end
      else if (srcTick)
         slotCnt_q <= slotCnt_q + 8'h01;
   end

   // A waveform alternates per frame, B per common slot
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         alternation <= 1'b0;
      else if (!running)
         alternation <= 1'b0;
      else if (waveCtrl_q[lsd_pkg::WC_WAVE_B] ? slotEnd : frameEnd)
         alternation <= ~alternation;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         frameTick <= 1'b0;
      else
         frameTick <= frameEnd;
   end

   // ------------------------------------------------------------
   // common, segment and supply outputs
   // ------------------------------------------------------------
   logic [3:0] comNext;

   always_comb
   begin
      comNext = 4'h1 << comIdx_q;
      if (comRepeat && duty == lsd_pkg::LSD_DUTY_STATIC)
         comNext = 4'hF;
      else if (comRepeat && duty == lsd_pkg::LSD_DUTY_HALF)
         comNext = comIdx_q[0] ? 4'hC : 4'h3;
      if (!running)
         comNext = 4'h0;
   end

   logic [3:0] groupCode;
   assign groupCode = pinFunc_q[lsd_pkg::PF_GROUP_HI:0];

   genvar g;
   generate
      for (g = 0; g < SEG_GROUPS; g++)
      begin : gen_group
         logic isSeg;
         // codes up to 8 fill from the bottom, above 8 drop from the bottom
         assign isSeg = (groupCode <= lsd_pkg::GROUP_ALL)
                        ? (4'(g) < groupCode)
                        : (4'(g) >= groupCode - lsd_pkg::GROUP_ALL);
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               segPinEnable[g*4 +: 4] <= 4'h0;
               segData[g*4 +: 4]      <= 4'h0;
            end
            else
            begin
               segPinEnable[g*4 +: 4] <= {lsd_pkg::GROUP_PINS{isSeg}};
               segData[g*4 +: 4]      <= (mainCtrl_q[lsd_pkg::MC_SHOW] && running && isSeg)
                                         ? memRowData[g*4 +: 4] : 4'h0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         comDrive      <= 4'h0;
         memRowSel     <= 2'h0;
         waveformB     <= 1'b0;
         driveSupplyOn <= 1'b0;
      end
      else
      begin
         comDrive      <= comNext;
         memRowSel     <= comIdx_q;
         waveformB     <= waveCtrl_q[lsd_pkg::WC_WAVE_B];
         driveSupplyOn <= mainCtrl_q[lsd_pkg::MC_SUPPLY] & running & ~standbyMode;
      end
   end
endmodule : lsd_segment_drive

/* File: testbench/lsd_drive_monitor.sv */
// concurrent checks on the segment lcd drive control top ports.
// assumes one clk domain and rst asynchronous, active high.
`timescale 1ns/1ns
module lsd_drive_monitor #(
   parameter int SEG_GROUPS = 8
) (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic [1:0]              regAddr,
   input wire logic [7:0]              regWdata,
   input wire logic                    regWrite,
   input wire logic                    regRead,
   input wire logic [7:0]              regRdata,
   input wire logic                    standbyMode,
   input wire logic [SEG_GROUPS*4-1:0] segData,
   input wire logic [SEG_GROUPS*4-1:0] segPinEnable,
   input wire logic                    waveformB,
   input wire logic                    driveSupplyOn,
   input wire logic                    frameTick
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_stands;
      !$past(regRead) |-> regRdata == 8'h00;
   endproperty
   a_rd_stands: assert property (p_rd_stands) else $error("read data outside slot");
   property p_main_top;
      $past(regRead) && $past(regAddr) == 2'h1 |-> regRdata[7];
   endproperty
   a_main_top: assert property (p_main_top) else $error("main bit 7 low");
   property p_wave_fixed;
      $past(regRead) && $past(regAddr) == 2'h2 |-> regRdata[6:5] == 2'h3;
   endproperty
   a_wave_fixed: assert property (p_wave_fixed) else $error("wave bits 6:5 low");
   property p_run_fixed;
      $past(regRead) && $past(regAddr) == 2'h3 |-> regRdata[7:1] == 7'h7F;
   endproperty
   a_run_fixed: assert property (p_run_fixed) else $error("run reg upper bits low");
   property p_standby_off;
      standbyMode && $past(standbyMode) |-> !driveSupplyOn;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("supply on in standby");
   property p_port_quiet;
      (segData & ~segPinEnable) == '0;
   endproperty
   a_port_quiet: assert property (p_port_quiet) else $error("data on port pin");
   property p_tick_pulse;
      frameTick |=> !frameTick [*8];
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("frame tick too close");
   property p_wave_copy;
      regWrite && regAddr == 2'h2 |-> ##2 waveformB == $past(regWdata[7], 2);
   endproperty
   a_wave_copy: assert property (p_wave_copy) else $error("waveform select not copied");
endmodule : lsd_drive_monitor

bind lsd_segment_drive lsd_drive_monitor #(.SEG_GROUPS(SEG_GROUPS)) i_mon (
   .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .standbyMode(standbyMode), .segData(segData),
   .segPinEnable(segPinEnable), .waveformB(waveformB), .driveSupplyOn(driveSupplyOn),
   .frameTick(frameTick));

/* File: testbench/lsd_mem_model.sv */
// display memory model feeding rows to the drive block.
// assumes the row is read combinationally on the same clock.
`timescale 1ns/1ns
module lsd_mem_model #(
   parameter int SEG_GROUPS = 8
) (
   input  wire logic [1:0]              memRowSel,
   output      logic [SEG_GROUPS*4-1:0] memRowData
);
   // never all zero, so a blanked row cannot pass for a shown one
   assign memRowData = {SEG_GROUPS{4'h5 + {2'h0, memRowSel}}};
endmodule : lsd_mem_model

/* File: testbench/test_lsd_segment_drive.sv */
// self-checking bench for the segment lcd drive control block.
// assumes 25 MHz clk and a fast subclock of ten clk periods.
`timescale 1ns/1ns
module test_lsd_segment_drive;
   logic        clk, rst, regWrite, regRead, subClkIn, lowPowerMode, standbyMode;
   logic [1:0]  regAddr, memRowSel;
   logic [7:0]  regWdata, regRdata;
   logic [31:0] memRowData, segData, segPinEnable, e;
   logic [3:0]  comDrive;
   logic        alternation, waveformB, driveSupplyOn, frameTick;
   int          errorCnt, checked, n;

   lsd_segment_drive i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .subClkIn(subClkIn),
      .lowPowerMode(lowPowerMode), .standbyMode(standbyMode), .memRowData(memRowData),
      .memRowSel(memRowSel), .comDrive(comDrive), .alternation(alternation),
      .waveformB(waveformB), .segData(segData), .segPinEnable(segPinEnable),
      .driveSupplyOn(driveSupplyOn), .frameTick(frameTick));
   lsd_mem_model i_mem (.memRowSel(memRowSel), .memRowData(memRowData));

   // ------------------------------------------------------------
   // bus cycles and checks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] x);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 check(regRdata, x);
   endtask : rd
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // counts cycles up to the next frame tick, or lim if none comes
   task automatic waitTick(input int lim, output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1 k++;
      end
      while (frameTick !== 1'b1 && k < lim);
   endtask : waitTick
   task automatic meas(output int k);
      waitTick(30000, k);
      waitTick(30000, k);
   endtask : meas

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic sReset;
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h80);
      rd(2'h2, 8'h7F);
      rd(2'h3, 8'hFF);
   endtask : sReset
   task automatic sReserved;
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h80);
      wr(2'h2, 8'h00);
      rd(2'h2, 8'h60);
      wr(2'h2, 8'h80);
      settle();
      check(32'(waveformB), 32'h1);
      wr(2'h2, 8'h00);
      wr(2'h3, 8'h00);
      rd(2'h3, 8'hFE);
      wr(2'h3, 8'h01);
   endtask : sReserved
   task automatic sPins;
      for (int c = 0; c < 16; c++)
      begin
         wr(2'h0, 8'(c));
         settle();
         e = (c <= 8) ? ~(32'hFFFF_FFFF << (4 * c)) : 32'hFFFF_FFFF << (4 * (c - 8));
         check(segPinEnable, e);
      end
   endtask : sPins
   task automatic sRun;
      wr(2'h0, 8'hC8);
      wr(2'h1, 8'h78);
      meas(n);
      check(n, 512);
      check(32'(driveSupplyOn), 32'h1);
      check(comDrive, 4'h8);
      check(segData, 32'h8888_8888);
      e[0] = alternation;
      waitTick(30000, n);
      check(32'(alternation != e[0]), 32'h1);
      wr(2'h2, 8'h80);
      waitTick(30000, n);
      e[0] = alternation;
      waitTick(30000, n);
      check(32'(alternation == e[0]), 32'h1);
      wr(2'h2, 8'h00);
      wr(2'h1, 8'h68);
      settle();
      check(segData, 32'h0);
      wr(2'h1, 8'h79);
      meas(n);
      check(n, 1024);
      wr(2'h0, 8'h88);
      meas(n);
      check(n, 768);
      wr(2'h1, 8'h7B);
      meas(n);
      check(n, 3072);
      wr(2'h0, 8'h28);
      settle();
      check(comDrive, 4'hF);
      wr(2'h0, 8'h68);
      waitTick(30000, n);
      check(comDrive, 4'hC);
   endtask : sRun
   task automatic sSupply;
      @(posedge clk);
      standbyMode <= 1'b1;
      settle();
      check(32'(driveSupplyOn), 32'h0);
      @(posedge clk);
      standbyMode <= 1'b0;
      wr(2'h1, 8'h58);
      settle();
      check({driveSupplyOn, comDrive}, 5'h00);
      rd(2'h1, 8'hD8);
      rd(2'h0, 8'h68);
      wr(2'h1, 8'h78);
      settle();
      check(32'(driveSupplyOn), 32'h1);
      wr(2'h1, 8'h38);
      settle();
      check(32'(driveSupplyOn), 32'h0);
      wr(2'h1, 8'h78);
      wr(2'h3, 8'h00);
      settle();
      check(32'(driveSupplyOn), 32'h0);
      wr(2'h3, 8'h01);
   endtask : sSupply
   task automatic sLowPower;
      @(posedge clk);
      lowPowerMode <= 1'b1;
      waitTick(2000, n);
      check(n, 2000);
      for (int s = 0; s < 3; s++)
      begin
         wr(2'h1, 8'h70 + 8'(s));
         meas(n);
         check(32'(n >= (2560 << s) - 2 && n <= (2560 << s) + 2), 32'h1);
      end
      @(posedge clk);
      lowPowerMode <= 1'b0;
   endtask : sLowPower

   task automatic wrapUp;
      if (errorCnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrapUp

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // free-running subclock, phase unrelated to clk
   initial
   begin
      subClkIn = 1'b0;
      #7;
      forever #200 subClkIn = ~subClkIn;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      errorCnt++;
      wrapUp();
   end
   initial
   begin
      {rst, regWrite, regRead, lowPowerMode, standbyMode} = 5'h10;
      regAddr  = 2'h0;
      regWdata = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      sReset();
      sReserved();
      sPins();
      sRun();
      sSupply();
      sLowPower();
      wrapUp();
   end
endmodule : test_lsd_segment_drive
